// ### rtl/pms_cfg.svh
// Register map, field positions and codes of the parallel mode status block
// Operation
// R1: The result code reads 0000 for compatible mode without negotiation, 0001 after a failed negotiation and 0010 for compatible mode after a 1284 mode ends.
// R2: The result code reads 0110 for EPP, 1000 reverse nibble, 1001 reverse nibble with ID, 1010 reverse byte and 1011 reverse byte with ID.
// R3: The result code reads 1100 for ECP without RLE, 1101 the same with ID, 1110 ECP with RLE and 1111 the same with ID.
// R4: The reserved codes 0100 and 0111 never appear in the result code field.
// R5: The undefined codes 0011 and 0101 never appear in the result code field either.
// R6: A change of port mode raises the mode-change interrupt when its enable bit is set.
// R7: Any write to the negotiation result status register clears it.
// R8: Software should clear the negotiation result status register after reading a result.
// R9: A rising edge on an input selected in the edge select register raises the signal-change interrupt when its enable is set.
// R10: Edge select bit 3 is the 1284-active input, bit 2 initialise, bit 1 host busy, bit 0 host strobe.
// R11: Edge select bits 7:4 are written as zero by software and always read as zero.
// R12: Edge select settings raise no signal-change interrupt outside Manual mode.
// R13: Any write to the interrupt status register clears pending status and drops the request.
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH

// Register indices; byte address is four times the index
`define PMS_IDX_IRQ_ENABLE 8'h22
`define PMS_IDX_IRQ_STATUS 8'h23
`define PMS_IDX_EDGE_SEL 8'h2d
`define PMS_IDX_NEG_STATUS 8'h2e
`define PMS_IDX_PORT_CTRL 8'h2f

// Reset values
`define PMS_RST_EDGE_SEL 8'h00
`define PMS_RST_IRQ_ENABLE 2'h0
`define PMS_RST_IRQ_STATUS 2'h0
`define PMS_RST_NEG_STATUS 8'h00
`define PMS_RST_MODE 4'h0

// Interrupt register fields
`define PMS_IRQ_NEG_BIT 5
`define PMS_IRQ_SIG_BIT 4

// Edge select fields
`define PMS_EDGE_ACTIVE_BIT 3
`define PMS_EDGE_INIT_BIT 2
`define PMS_EDGE_BUSY_BIT 1
`define PMS_EDGE_STROBE_BIT 0
`define PMS_EDGE_WIDTH 4

// Port control fields
`define PMS_CTRL_MANUAL_BIT 0

// Result codes
`define PMS_CODE_COMPAT 4'h0
`define PMS_CODE_FAILED 4'h1
`define PMS_CODE_TERMINATED 4'h2
`define PMS_CODE_UNDEF_A 4'h3
`define PMS_CODE_RSVD_A 4'h4
`define PMS_CODE_UNDEF_B 4'h5
`define PMS_CODE_EPP 4'h6
`define PMS_CODE_RSVD_B 4'h7
`define PMS_CODE_NIBBLE 4'h8
`define PMS_CODE_NIBBLE_ID 4'h9
`define PMS_CODE_BYTE 4'ha
`define PMS_CODE_BYTE_ID 4'hb
`define PMS_CODE_ECP 4'hc
`define PMS_CODE_ECP_ID 4'hd
`define PMS_CODE_ECP_RLE 4'he
`define PMS_CODE_ECP_RLE_ID 4'hf

`endif

// ### rtl/pms_pkg.sv
// Types of the parallel mode status block
package pms_pkg;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
  } pms_edge_state_t;

  typedef struct packed {
    logic [7:0] edge_sel;
    logic [1:0] irq_en;
    logic [1:0] irq_sts;
    logic [3:0] neg_flags;
    logic [3:0] neg_code;
    logic [3:0] mode;
    logic manual;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } pms_state_t;

endpackage

// ### rtl/pms_edge_sync.sv
// Pin synchroniser and rising edge detector for the host handshake inputs
`timescale 1ns/1ps
`default_nettype none
`include "pms_cfg.svh"
module pms_edge_sync
  import pms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [`PMS_EDGE_WIDTH-1:0] pins,
  output logic [`PMS_EDGE_WIDTH-1:0] rise
);

  pms_edge_state_t q;
  pms_edge_state_t d;

  always_comb
  begin
    d = q;
    d.sync1 = pins;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Low in the previous cycle, high now
  genvar i;
  generate
    for (i = 0; i < `PMS_EDGE_WIDTH; i++)
    begin : g_rise
      assign rise[i] = q.sync2[i] & ~q.prev[i];
    end
  endgenerate

endmodule
`default_nettype wire

// ### rtl/pms_top.sv
// Parallel port mode status, edge detect and interrupt logic with APB access
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pms_cfg.svh"
module pms_top
  import pms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic neg_update,
  input wire logic [3:0] neg_code,
  input wire logic neg_ok,
  input wire logic neg_failed,
  input wire logic host_timeout,
  input wire logic immed_term,
  input wire logic ieee_mode_active_in,
  input wire logic host_initialise_in,
  input wire logic host_busy_in,
  input wire logic host_strobe_in,
  output logic irq,
  output logic [3:0] mode_code_out,
  output logic manual_mode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Host pin edges

  logic [`PMS_EDGE_WIDTH-1:0] pin_vec;
  logic [`PMS_EDGE_WIDTH-1:0] pin_rise;

  assign pin_vec[`PMS_EDGE_ACTIVE_BIT] = ieee_mode_active_in; // [R10]
  assign pin_vec[`PMS_EDGE_INIT_BIT] = host_initialise_in; // [R10]
  assign pin_vec[`PMS_EDGE_BUSY_BIT] = host_busy_in; // [R10]
  assign pin_vec[`PMS_EDGE_STROBE_BIT] = host_strobe_in; // [R10]

  pms_edge_sync u_edge
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .pins(pin_vec),
    .rise(pin_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic code_legal(input logic [3:0] c);
    begin
      unique case (c)
        `PMS_CODE_UNDEF_A, `PMS_CODE_UNDEF_B: code_legal = 1'b0; // [R5]
        `PMS_CODE_RSVD_A, `PMS_CODE_RSVD_B: code_legal = 1'b0; // [R4]
        default: code_legal = 1'b1; // [R1] [R2] [R3]
      endcase
    end
  endfunction

  pms_state_t q;
  pms_state_t d;

  logic setup_ph;
  logic access_ok;
  logic wr_en;
  logic rd_en;
  logic [5:0] idx;
  logic [7:0] hit_idx;
  logic hit;
  logic [31:0] rd_mux;
  logic neg_event;
  logic sig_event;
  logic [7:0] irq_sts_view;
  logic [7:0] irq_en_view;

  assign idx = paddr[7:2];
  assign hit_idx = {2'h0, idx};
  assign setup_ph = psel & ~penable;
  assign access_ok = psel & penable & q.pready & ~q.pslverr;
  assign wr_en = access_ok & pwrite;
  assign rd_en = access_ok & ~pwrite;

  always_comb
  begin
    irq_sts_view = 8'h00;
    irq_sts_view[`PMS_IRQ_NEG_BIT] = q.irq_sts[1];
    irq_sts_view[`PMS_IRQ_SIG_BIT] = q.irq_sts[0];
    irq_en_view = 8'h00;
    irq_en_view[`PMS_IRQ_NEG_BIT] = q.irq_en[1];
    irq_en_view[`PMS_IRQ_SIG_BIT] = q.irq_en[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    hit = 1'b1;
    if (paddr[1:0] != 2'h0)
    begin
      hit = 1'b0;
    end
    else
    begin
      unique case (hit_idx)
        `PMS_IDX_EDGE_SEL: rd_mux = {24'h00_0000, 4'h0, q.edge_sel[3:0]}; // [R11]
        `PMS_IDX_IRQ_ENABLE: rd_mux = {24'h00_0000, irq_en_view};
        `PMS_IDX_IRQ_STATUS: rd_mux = {24'h00_0000, irq_sts_view};
        `PMS_IDX_NEG_STATUS: rd_mux = {24'h00_0000, q.neg_flags, q.neg_code};
        `PMS_IDX_PORT_CTRL: rd_mux = {31'h0000_0000, q.manual};
        default: hit = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events

  // Only legal codes that differ from the current mode count as a change
  assign neg_event = neg_update & code_legal(neg_code) & (neg_code != q.mode); // [R6]
  assign sig_event = q.manual & |(pin_rise & q.edge_sel[3:0]); // [R9] [R12]

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    d = q;
    d.pready = 1'b0;
    d.pslverr = 1'b0;

    // One wait-free access phase after each setup
    if (setup_ph)
    begin
      d.pready = 1'b1;
      d.pslverr = ~hit;
      d.prdata = rd_mux;
    end

    if (wr_en)
    begin
      unique case (hit_idx)
        `PMS_IDX_EDGE_SEL: d.edge_sel = {4'h0, pwdata[3:0]}; // [R11]
        `PMS_IDX_IRQ_ENABLE:
        begin
          d.irq_en[1] = pwdata[`PMS_IRQ_NEG_BIT];
          d.irq_en[0] = pwdata[`PMS_IRQ_SIG_BIT];
        end
        `PMS_IDX_IRQ_STATUS: d.irq_sts = `PMS_RST_IRQ_STATUS; // [R13]
        `PMS_IDX_NEG_STATUS:
        begin
          d.neg_flags = 4'h0; // [R7]
          d.neg_code = `PMS_CODE_COMPAT; // [R7]
        end
        `PMS_IDX_PORT_CTRL: d.manual = pwdata[`PMS_CTRL_MANUAL_BIT];
        default: d.manual = q.manual;
      endcase
    end

    // Read of the interrupt status clears it
    if (rd_en && (hit_idx == `PMS_IDX_IRQ_STATUS))
    begin
      d.irq_sts = `PMS_RST_IRQ_STATUS;
    end

    // Sets after clears, so a coincident event survives
    if (neg_update && code_legal(neg_code))
    begin
      d.neg_code = neg_code; // [R1] [R2] [R3] [R4] [R5]
      d.mode = neg_code;
    end
    d.neg_flags = d.neg_flags | {neg_ok, neg_failed, host_timeout, immed_term};
    if (neg_event)
    begin
      d.irq_sts[1] = 1'b1; // [R6]
    end
    if (sig_event)
    begin
      d.irq_sts[0] = 1'b1; // [R9]
    end

    d.irq = |(d.irq_sts & d.irq_en); // [R6] [R9] [R13]
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;
  assign mode_code_out = q.mode;
  assign manual_mode_out = q.manual;

endmodule
`default_nettype wire

// ### test/pms_checker.sv
// Port-level assertions of the parallel mode status block
`timescale 1ns/1ps
`default_nettype none
module pms_checker
  import pms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic neg_update,
  input wire logic [3:0] neg_code,
  input wire logic irq,
  input wire logic [3:0] mode_code_out,
  input wire logic manual_mode_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic acc;
  assign acc = psel && penable && pready;
  a_mode_take:
    assert property (neg_update && !(neg_code inside {4'h3, 4'h4, 4'h5, 4'h7})
      |=> mode_code_out == $past(neg_code)) else $error("mode code not taken");
  a_rsvd_hold:
    assert property (neg_update && neg_code inside {4'h4, 4'h7} |=> $stable(mode_code_out))
      else $error("reserved code changed mode");
  a_undef_hold:
    assert property (neg_update && neg_code inside {4'h3, 4'h5} |=> $stable(mode_code_out))
      else $error("undefined code changed mode");
  a_never_code:
    assert property (!(mode_code_out inside {4'h3, 4'h4, 4'h5, 4'h7}))
      else $error("illegal mode code shown");
  a_irq_clear:
    assert property (acc && pwrite && paddr == 8'h8c && !neg_update && !manual_mode_out
      ##1 !neg_update |=> !irq) else $error("irq kept after status write");
  a_sel_upper:
    assert property (acc && !pwrite && paddr == 8'hb4 |-> prdata[7:4] == 4'h0)
      else $error("edge select upper bits set");
  a_irq_cause:
    assert property ($rose(irq) |-> $past(neg_update) || $past(manual_mode_out)
      || $past(psel && pwrite)) else $error("irq without cause");
  a_ready_pulse:
    assert property (psel && !penable |=> pready ##1 !pready) else $error("pready timing");
  a_err_align:
    assert property (acc && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned no error");
endmodule
bind pms_top pms_checker chk_u (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .neg_update(neg_update), .neg_code(neg_code), .irq(irq),
  .mode_code_out(mode_code_out), .manual_mode_out(manual_mode_out));
`default_nettype wire

// ### test/pms_host_model.sv
// Host-side model driving the four handshake lines
`timescale 1ns/1ps
`default_nettype none
module pms_host_model
  import pms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] line_req,
  output logic ieee_mode_active_in,
  output logic host_initialise_in,
  output logic host_busy_in,
  output logic host_strobe_in
);
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      {ieee_mode_active_in, host_initialise_in, host_busy_in, host_strobe_in} <= 4'h0;
    else
      {ieee_mode_active_in, host_initialise_in, host_busy_in, host_strobe_in} <= line_req;
endmodule
`default_nettype wire

// ### test/parallel_mode_status_and_edge_detect_test.sv
// Self-checking bench for the parallel mode status block
`timescale 1ns/1ps
`default_nettype none
module parallel_mode_status_and_edge_detect_test;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, rerr, neg_update, irq, legal;
  logic manual_mode_out, act, ini, bsy, stb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] neg_code, mode_code_out, line_req, flags, exp_mode, c;
  int failures, check_count, i;
  pms_top dut_u (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .neg_update(neg_update), .neg_code(neg_code), .neg_ok(flags[3]),
    .neg_failed(flags[2]), .host_timeout(flags[1]), .immed_term(flags[0]),
    .ieee_mode_active_in(act), .host_initialise_in(ini), .host_busy_in(bsy),
    .host_strobe_in(stb), .irq(irq), .mode_code_out(mode_code_out),
    .manual_mode_out(manual_mode_out));
  pms_host_model host_u (.ref_clk(ref_clk), .rst(rst), .line_req(line_req),
    .ieee_mode_active_in(act), .host_initialise_in(ini), .host_busy_in(bsy),
    .host_strobe_in(stb));
  initial
  begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task complete_run();
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      complete_run();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask
  task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(name, rd, exp);
  endtask
  task neg(input logic [3:0] code);
    neg_update <= 1'h1;
    neg_code <= code;
    @(posedge ref_clk);
    neg_update <= 1'h0;
    tick(3);
  endtask
  initial
  begin
    tick(20000);
    failures++;
    complete_run();
  end
  initial
  begin
    {rst, psel, penable, pwrite, neg_update} = 5'h10;
    {paddr, pwdata, neg_code, line_req, flags} = 52'h0;
    tick(12);
    rst <= 1'h0;
    tick(1);
    rdc("edge_sel", 8'hb4, 32'h0);
    rdc("neg_sts", 8'hb8, 32'h0);
    apb(1'h1, 8'hb4, 32'hff);
    rdc("edge_sel", 8'hb4, 32'hf);
    apb(1'h1, 8'h88, 32'h30);
    exp_mode = 4'h0;
    for (i = 0; i < 16; i++)
    begin
      c = i[3:0];
      legal = !(c inside {4'h3, 4'h4, 4'h5, 4'h7});
      neg(c);
      check("irq", irq, legal && c != exp_mode);
      if (legal)
        exp_mode = c;
      check("mode", mode_code_out, exp_mode);
      rdc("neg_sts", 8'hb8, legal ? c : 4'h0);
      apb(1'h1, 8'hb8, 32'h5a);
      apb(1'h1, 8'h8c, 32'h0);
      tick(1);
      check("irq", irq, 32'h0);
      rdc("neg_sts", 8'hb8, 32'h0);
    end
    apb(1'h1, 8'h88, 32'h0);
    neg(4'h6);
    check("irq", irq, 32'h0);
    apb(1'h1, 8'h88, 32'h20);
    tick(1);
    check("irq", irq, 32'h1);
    rdc("irq_sts", 8'h8c, 32'h20);
    tick(1);
    check("irq", irq, 32'h0);
    flags <= 4'hf;
    tick(1);
    flags <= 4'h0;
    rdc("neg_sts", 8'hb8, 32'hf6);
    apb(1'h1, 8'h88, 32'h10);
    apb(1'h1, 8'hb4, 32'hf);
    line_req <= 4'hf;
    tick(8);
    check("irq", irq, 32'h0);
    line_req <= 4'h0;
    apb(1'h1, 8'hbc, 32'h1);
    tick(4);
    check("manual", manual_mode_out, 32'h1);
    rdc("port_ctrl", 8'hbc, 32'h1);
    for (i = 0; i < 4; i++)
    begin
      apb(1'h1, 8'hb4, 32'h1 << i);
      line_req <= 4'h1 << ((i + 1) % 4);
      tick(8);
      check("irq", irq, 32'h0);
      line_req <= line_req | (4'h1 << i);
      tick(8);
      check("irq", irq, 32'h1);
      line_req <= 4'h0;
      rdc("irq_sts", 8'h8c, 32'h10);
    end
    apb(1'h0, 8'h40, 32'h0);
    check("rd_err", rerr, 32'h1);
    apb(1'h1, 8'hb5, 32'h0);
    check("wr_err", rerr, 32'h1);
    rdc("edge_sel", 8'hb4, 32'h8);
    complete_run();
  end
endmodule
`default_nettype wire
